// file: two_wire_slave_port_bench.sv
// Self-checking bench of the two-wire slave port
`timescale 1ns/10ps
module two_wire_slave_port_bench;
  import tws_pkg::*;
  // ----------------------------------------
  // Signals and ordinary cases
  // ----------------------------------------
  typedef struct {
    logic [2:0] asel;
    logic busy;
    logic store;
    logic [7:0] addr;
    logic [7:0] data;
    logic ack_a;
    logic ack_d;
    logic pushed;
    logic commit;
  } tws_row_t;
  // Mismatched address or busy store must refuse the whole transfer
  tws_row_t rows [7] = '{
    '{3'h2, 1'b0, 1'b0, 8'ha4, 8'h5a, 1'b1, 1'b1, 1'b1, 1'b0},
    '{3'h2, 1'b0, 1'b0, 8'ha6, 8'h5a, 1'b0, 1'b0, 1'b0, 1'b0},
    '{3'h2, 1'b0, 1'b0, 8'h64, 8'h5a, 1'b0, 1'b0, 1'b0, 1'b0},
    '{3'h2, 1'b1, 1'b0, 8'ha4, 8'h5a, 1'b0, 1'b0, 1'b0, 1'b0},
    '{3'h7, 1'b0, 1'b0, 8'hae, 8'h00, 1'b1, 1'b1, 1'b1, 1'b0},
    '{3'h2, 1'b0, 1'b1, 8'ha4, 8'h3f, 1'b1, 1'b1, 1'b1, 1'b1},
    '{3'h2, 1'b0, 1'b0, 8'ha4, 8'h3f, 1'b1, 1'b1, 1'b1, 1'b0}};
  logic ref_clk = 1'b0; // System clock
  logic rst_b; // Reset, active low
  logic scl; // Bus clock from master
  logic m_sda_low; // Master pulls data low
  logic sda_out; // Device drive level
  logic sda_oe; // Device pulls data low
  wire logic sda_line = (m_sda_low | (sda_oe & ~sda_out)) ? 1'b0 : 1'b1; // Pulled-up wire
  logic [2:0] asel; // Address select bits
  logic store_sel; // Deferred store selected
  logic nv_busy; // Store in progress
  logic commit; // Store pulse
  logic rx_valid; // Received byte waiting
  logic rx_ready; // Drain accepts
  logic [7:0] rx_data; // Received byte
  logic rx_first; // First data byte flag
  logic tx_valid; // Read byte offered
  tws_byte_t tx_data; // Read byte
  logic tx_ready; // Read byte taken
  logic link_active; // Transfer in progress
  int fail_count = 0; // Mismatches
  int checked = 0; // Comparisons
  int commits = 0; // Store pulses seen
  int tx_taken = 0; // Read bytes taken
  logic a; // Ack seen by master
  logic [7:0] b; // Byte read by master
  always #5 ref_clk = ~ref_clk;
  // Count pulses; next read byte follows each take
  always @(posedge ref_clk) begin
    if (commit === 1'b1) begin
      commits <= commits + 1;
    end
    if (tx_ready === 1'b1 && tx_valid === 1'b1) begin
      tx_taken <= tx_taken + 1;
      tx_data <= tx_data + 8'h11;
    end
  end
  tws_bus_master tws_bus_master_inst (.scl(scl), .sda_low(m_sda_low), .sda(sda_line));
  tws_slave_port #(.DEV_ID(4'ha)) tws_slave_port_inst (.ref_clk(ref_clk), .rst_b(rst_b), .scl_in(scl),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .bus_address_select_bits(asel),
    .deferred_store_select(store_sel), .nv_busy(nv_busy), .commit_to_nonvolatile_command(commit),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data), .rx_first(rx_first), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .link_active(link_active));
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      $display("Error at %0t ns: %s got %h expected %h", $time, what, got, exp);
      fail_count++;
    end
  endtask
  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Wait, bounded, for a received byte, compare it and pop it
  task automatic pop_rx(input logic [7:0] exp, input logic first);
    int n;
    n = 0;
    @(posedge ref_clk);
    #1;
    while (rx_valid !== 1'b1 && n < 100) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    if (n == 100) begin
      $display("Error at %0t ns: no received byte", $time);
      fail_count++;
      finish_test();
    end
    cmp(rx_data, exp, "received byte");
    cmp({7'h00, rx_first}, {7'h00, first}, "first flag");
    @(posedge ref_clk) rx_ready <= 1'b1;
    @(posedge ref_clk) rx_ready <= 1'b0;
  endtask
  // One write transfer of an ordinary row
  task automatic wr_txn(input tws_row_t r);
    int c0;
    @(posedge ref_clk);
    asel <= r.asel;
    nv_busy <= r.busy;
    store_sel <= r.store;
    c0 = commits;
    tws_bus_master_inst.start();
    tws_bus_master_inst.wr_byte(r.addr, a);
    cmp({7'h00, a}, {7'h00, r.ack_a}, "address ack");
    tws_bus_master_inst.wr_byte(r.data, a);
    cmp({7'h00, a}, {7'h00, r.ack_d}, "data ack");
    tws_bus_master_inst.stop();
    cmp(8'(commits - c0), {7'h00, r.commit}, "store pulse");
    if (r.pushed) begin
      pop_rx(r.data, 1'b1);
    end else begin
      cmp({7'h00, rx_valid}, 8'h00, "no byte kept");
    end
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst_b = 1'b0;
    rx_ready = 1'b0;
    tx_valid = 1'b0;
    tx_data = 8'h00;
    asel = 3'h2;
    store_sel = 1'b0;
    nv_busy = 1'b0;
    repeat (20) @(posedge ref_clk);
    rst_b <= 1'b1;
    #1;
    cmp({4'h0, sda_out, sda_oe, link_active, rx_valid}, 8'h00, "reset outputs");
    $display("Test reset done");
    repeat (3) @(posedge ref_clk);
    foreach (rows[i]) begin
      wr_txn(rows[i]);
    end
    $display("Test table done");
    // Slow standard rate reuses the first row
    tws_bus_master_inst.h = 5000.0;
    wr_txn(rows[0]);
    tws_bus_master_inst.h = 62.5;
    $display("Test standard rate done");
    // Read two bytes, nack the last, then repeated start into a write
    @(posedge ref_clk);
    tx_valid <= 1'b1;
    tx_data <= 8'hc3;
    tws_bus_master_inst.start();
    tws_bus_master_inst.wr_byte(8'ha5, a);
    cmp({7'h00, a}, 8'h01, "read address ack");
    tws_bus_master_inst.rd_byte(1'b1, b);
    cmp(b, 8'hc3, "first read byte");
    tws_bus_master_inst.rd_byte(1'b0, b);
    cmp(b, 8'hd4, "second read byte");
    repeat (6) @(posedge ref_clk);
    #1;
    cmp({6'h00, sda_oe, link_active}, 8'h01, "line released after nack");
    cmp(8'(tx_taken), 8'h02, "bytes taken");
    tws_bus_master_inst.start();
    tws_bus_master_inst.wr_byte(8'ha4, a);
    cmp({7'h00, a}, 8'h01, "ack after repeated start");
    tws_bus_master_inst.wr_byte(8'h77, a);
    tws_bus_master_inst.stop();
    @(posedge ref_clk) tx_valid <= 1'b0;
    pop_rx(8'h77, 1'b1);
    $display("Test read done");
    // Receiver stalls: two bytes fill the buffer, the third is refused
    tws_bus_master_inst.start();
    tws_bus_master_inst.wr_byte(8'ha4, a);
    tws_bus_master_inst.wr_byte(8'h11, a);
    cmp({7'h00, a}, 8'h01, "stall byte one ack");
    tws_bus_master_inst.wr_byte(8'h22, a);
    cmp({7'h00, a}, 8'h01, "stall byte two ack");
    tws_bus_master_inst.wr_byte(8'h33, a);
    cmp({7'h00, a}, 8'h00, "full buffer nack");
    tws_bus_master_inst.stop();
    pop_rx(8'h11, 1'b1);
    pop_rx(8'h22, 1'b0);
    repeat (2) @(posedge ref_clk);
    #1;
    cmp({6'h00, rx_valid, link_active}, 8'h00, "drained and idle");
    $display("Test stall done");
    // Reset in mid-transfer with a byte waiting, then a clean transfer
    tws_bus_master_inst.start();
    tws_bus_master_inst.wr_byte(8'ha4, a);
    tws_bus_master_inst.wr_byte(8'h99, a);
    @(posedge ref_clk) rst_b <= 1'b0;
    // Bus returns to idle while the port is held in reset
    tws_bus_master_inst.stop();
    @(posedge ref_clk);
    #1;
    cmp({4'h0, sda_out, sda_oe, link_active, rx_valid}, 8'h00, "outputs in mid-run reset");
    @(posedge ref_clk) rst_b <= 1'b1;
    repeat (3) @(posedge ref_clk);
    wr_txn(rows[0]);
    $display("Test mid-run reset done");
    finish_test();
  end
endmodule // two_wire_slave_port_bench

// file: tws_bus_master.sv
// Bus master model for the two-wire slave port
`timescale 1ns/10ps
module tws_bus_master (
  output logic scl, // Bus clock, high between frames
  output logic sda_low, // High while pulling data low
  input wire logic sda // Resolved data line level
);
  // ----------------------------------------
  // Bit and condition timing
  // ----------------------------------------
  real h = 62.5; // Half bus clock period, 8 MHz rate
  real q = 15.0; // Data moves this long after clock fall
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // one pulse a bit, data moves only while clock low
  task automatic clk_bit(input logic drv_low, output logic [1:0] s);
    #(q);
    sda_low = drv_low;
    #(h - q);
    scl = 1'b1;
    #(h / 2);
    s[1] = sda;
    #(h / 2);
    s[0] = sda;
    scl = 1'b0;
  endtask
  // data falls with clock high, from idle or as a repeat
  task automatic start();
    #(q);
    sda_low = 1'b0;
    #(h - q);
    scl = 1'b1;
    #(h);
    sda_low = 1'b1;
    #(h);
    scl = 1'b0;
  endtask
  task automatic stop();
    #(q);
    sda_low = 1'b1;
    #(h - q);
    scl = 1'b1;
    #(h);
    sda_low = 1'b0;
    #(h);
  endtask
  // ninth pulse given; ack only if low at both samples, mid and end of the high phase
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic [1:0] s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(~b[i], s);
    end
    clk_bit(1'b0, s);
    ack = (s === 2'b00);
  endtask
  // master acks all but the last byte; a bit moving in high phase reads unknown
  task automatic rd_byte(input logic give_ack, output logic [7:0] b);
    logic [1:0] s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b0, s);
      b[i] = (s[1] === s[0]) ? s[1] : 1'bx;
    end
    clk_bit(give_ack, s);
  endtask
endmodule // tws_bus_master

// file: tws_defines.svh
// Constants of the two-wire slave port
// Summary of operation
// - Slave only; never drives clock or conditions
// - START: data falls while clock high
// - STOP: data rises while clock high
// - Data changes only while clock low
// - One clock per bit, eight bits, ack
// - Works in standard and fast mode
// - Ack holds data low whole high phase
// - Nonvolatile write busy: refuse every request
// - Master nacks last read byte; release line
// - Write: address then acknowledged data bytes
// - Read: ack address, then transmit bytes
// - Repeated START ends and restarts transfer
// - Unlimited bytes per transfer, master decides
// - Address byte: identifier, address bits, direction
// - Read direction: transmit until STOP or START
// - Recognise conditions, match address in hardware
// - Three address bits select bus address
// - Store command commits registers; bus refused
`ifndef TWS_DEFINES_SVH
`define TWS_DEFINES_SVH
// Address byte field positions
`define TWS_RW_BIT 0
`define TWS_AD_LSB 1
`define TWS_AD_MSB 3
`define TWS_ID_LSB 4
`define TWS_ID_MSB 7
// Arbitrary default identifier
`define TWS_ID_DEFAULT 4'h5
// Store command code
`define TWS_STORE_CMD 8'h3f
// Reference clock and fastest bus rate
`define TWS_REF_KHZ 100000
`define TWS_STD_KHZ 100
`define TWS_FAST_KHZ 400
`define TWS_SCL_MIN_CYC (`TWS_REF_KHZ / `TWS_FAST_KHZ)
`define TWS_BUF_DEPTH 2
`endif

// file: tws_pkg.sv
// Types of the two-wire slave port
package tws_pkg;
  // Serial byte
  typedef logic [7:0] tws_byte_t;
  // Protocol states
  typedef enum logic [2:0] {
    S_IDLE, S_ADDR, S_RX, S_ACK, S_TX, S_TX_ACK, S_IGNORE
  } tws_state_t;
endpackage

// file: tws_skid_buf.sv
// Two-entry buffer on the received-byte path
`timescale 1ns/10ps
module tws_skid_buf #(
  parameter int DW = 9,
  parameter int DEPTH = 2
) (
  input wire logic ref_clk, // System clock
  input wire logic rst_b, // Async reset, active low
  tws_stream_if.snk in_if, // Filling side
  output logic out_valid, // Word available
  input wire logic out_ready, // Drain accepts
  output logic [DW-1:0] out_data // Oldest word
);
  import tws_pkg::*;
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || DW < 1) begin : g_chk
    $error("tws_skid_buf: DEPTH must be a power of two >= 2");
  end
  logic [DW-1:0] mem_q [DEPTH]; // Storage
  logic [AW-1:0] wr_q; // Write pointer
  logic [AW-1:0] rd_q; // Read pointer
  logic [AW:0] cnt_q; // Fill level
  logic push; // Write fires
  logic pop; // Read fires
  // Full refuses, so the core nacks instead of losing bytes
  assign in_if.ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  assign push = in_if.valid & in_if.ready;
  assign pop = out_valid & out_ready;
  // Storage write
  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_q[wr_q] <= in_if.data;
    end
  end
  // Pointers and level
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  property p_full_refuses;
    @(posedge ref_clk) disable iff (!rst_b)
      (cnt_q == (AW+1)'(DEPTH)) |-> !in_if.ready && (wr_q == rd_q);
  endproperty
  a_full_refuses: assert property (p_full_refuses) else $error("buffer full but ready");
endmodule // tws_skid_buf

// file: tws_slave_port.sv
// Two-wire slave port: condition detection, address match, byte transfer
`timescale 1ns/10ps
`include "tws_defines.svh"
module tws_slave_port #(
  parameter logic [3:0] DEV_ID = `TWS_ID_DEFAULT // Arbitrary identifier value
) (
  input wire logic ref_clk, // System clock, 100 MHz
  input wire logic rst_b, // Async reset, active low
  input wire logic scl_in, // Bus clock pin level
  input wire logic sda_in, // Bus data pin level
  output logic sda_out, // Data drive level, always low
  output logic sda_oe, // High while pulling data low
  input wire logic [2:0] bus_address_select_bits, // Device address bits
  input wire logic deferred_store_select, // Writes held until store
  input wire logic nv_busy, // Nonvolatile write in progress
  output logic commit_to_nonvolatile_command, // Store pulse
  output logic rx_valid, // Received byte available
  input wire logic rx_ready, // Received byte taken
  output logic [7:0] rx_data, // Received byte
  output logic rx_first, // Byte is first after address
  input wire logic tx_valid, // Read byte offered
  input wire tws_pkg::tws_byte_t tx_data, // Read byte
  output logic tx_ready, // Read byte taken this cycle
  output logic link_active // Transfer in progress
);
  import tws_pkg::*;

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  // fast mode sampling margin
  // Fast mode needs enough samples per bus clock
  if (`TWS_SCL_MIN_CYC < 16) begin : g_chk
    $error("tws_slave_port: reference clock too slow");
  end

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic scl_s; // Synchronised clock line
  logic sda_s; // Synchronised data line
  logic scl_p_q; // Clock line one cycle back
  logic sda_p_q; // Data line one cycle back
  logic scl_rise; // Clock rising edge
  logic scl_fall; // Clock falling edge
  logic start_det; // START or repeated START
  logic stop_det; // STOP
  tws_state_t state_q; // Protocol state
  logic [2:0] cnt_q; // Bit counter
  logic full_q; // Eight bits shifted in
  logic [7:0] sh_q; // Receive shift register
  logic rw_q; // Direction, high for read
  logic first_q; // Next data byte is first
  logic mack_q; // Master acknowledged
  logic [7:0] tx_sh_q; // Transmit shift register
  logic sda_oe_q; // Data pull-down enable
  logic commit_q; // Store command pulse
  logic dec; // Ninth-bit decision edge
  logic addr_match; // Address byte is ours
  logic addr_ack; // Address accepted
  logic rx_fire; // Data byte pushed and acked
  logic tx_take; // Next read byte loaded
  logic [1:0] pins; // Pin bundle

  // Stream into the buffer
  tws_stream_if #(.DW(9)) rx_if ();

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  assign pins = {scl_in, sda_in};

  tws_sync #(.W(2)) u_sync (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .async_in(pins),
    .sync_out({scl_s, sda_s})
  );

  // Delayed copies for edge finding
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
    end else begin
      scl_p_q <= scl_s;
      sda_p_q <= sda_s;
    end
  end

  // ----------------------------------------
  // Edge and condition detection
  // ----------------------------------------
  assign scl_rise = scl_s & ~scl_p_q;
  assign scl_fall = ~scl_s & scl_p_q;
  assign start_det = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign stop_det = scl_s & scl_p_q & ~sda_p_q & sda_s;

  // ----------------------------------------
  // Decisions
  // ----------------------------------------
  // identifier and address bits, not direction
  assign addr_match = (sh_q[`TWS_ID_MSB:`TWS_ID_LSB] == DEV_ID) &&
                      (sh_q[`TWS_AD_MSB:`TWS_AD_LSB] == bus_address_select_bits);
  // Decision on the fall that ends the eighth bit
  assign dec = scl_fall & full_q & ((state_q == S_ADDR) | (state_q == S_RX));
  assign addr_ack = addr_match & ~nv_busy;
  // data byte pushed only when room and not busy
  assign rx_if.valid = dec & (state_q == S_RX) & ~nv_busy;
  assign rx_if.data = {first_q, sh_q};
  assign rx_fire = rx_if.valid & rx_if.ready;
  // load next read byte after ack
  assign tx_take = scl_fall & tx_valid &
                   (((state_q == S_ACK) & rw_q) | ((state_q == S_TX_ACK) & mack_q));
  assign tx_ready = tx_take;

  // ----------------------------------------
  // Protocol state
  // ----------------------------------------
  // Conditions override every state
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= S_IDLE;
    end else if (start_det) begin
      state_q <= S_ADDR;
    end else if (stop_det) begin
      state_q <= S_IDLE;
    end else begin
      unique case (state_q)
        S_IDLE, S_IGNORE: begin
          // Wait for next START
          state_q <= state_q;
        end
        S_ADDR: begin
          if (dec) begin
            state_q <= addr_ack ? S_ACK : S_IGNORE;
          end
        end
        S_RX: begin
          // leaves RX on the eighth-bit decision, to ACK if pushed
          if (dec) begin
            state_q <= rx_fire ? S_ACK : S_IGNORE;
          end
        end
        S_ACK: begin
          if (scl_fall) begin
            if (rw_q) begin
              state_q <= tx_take ? S_TX : S_IGNORE;
            end else begin
              state_q <= S_RX;
            end
          end
        end
        S_TX: begin
          if (scl_fall && cnt_q == 3'd7) begin
            state_q <= S_TX_ACK;
          end
        end
        S_TX_ACK: begin
          if (scl_fall) begin
            state_q <= tx_take ? S_TX : S_IGNORE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // Bit counting
  // ----------------------------------------
  // eight bits then a ninth
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 3'h0;
      full_q <= 1'b0;
    end else if (start_det) begin
      cnt_q <= 3'h0;
      full_q <= 1'b0;
    end else if (scl_rise && (state_q == S_ADDR || state_q == S_RX)) begin
      // Counter wraps to zero on the eighth bit
      cnt_q <= cnt_q + 3'h1;
      full_q <= (cnt_q == 3'd7);
    end else if (dec) begin
      full_q <= 1'b0;
    end else if (scl_fall && state_q == S_ACK) begin
      cnt_q <= 3'h0;
    end else if (scl_fall && state_q == S_TX) begin
      cnt_q <= cnt_q + 3'h1;
    end
  end

  // Receive shift, data sampled on the rising clock
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sh_q <= 8'h00;
    end else if (scl_rise && (state_q == S_ADDR || state_q == S_RX)) begin
      sh_q <= {sh_q[6:0], sda_s};
    end
  end

  // Direction and first-byte marker
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rw_q <= 1'b0;
      first_q <= 1'b0;
    end else if (start_det) begin
      first_q <= 1'b0;
    end else if (dec && state_q == S_ADDR) begin
      rw_q <= sh_q[`TWS_RW_BIT];
      first_q <= 1'b1;
    end else if (rx_fire) begin
      first_q <= 1'b0;
    end
  end

  // Master acknowledge sampled on the ninth rising clock
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      mack_q <= 1'b0;
    end else if (scl_rise && state_q == S_TX_ACK) begin
      mack_q <= ~sda_s;
    end
  end

  // Transmit shift, next bit presented on each falling clock
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_sh_q <= 8'h00;
    end else if (tx_take) begin
      tx_sh_q <= tx_data;
    end else if (scl_fall && state_q == S_TX) begin
      tx_sh_q <= {tx_sh_q[6:0], 1'b0};
    end
  end

  // ----------------------------------------
  // Data line drive
  // ----------------------------------------
  // drive changes on falling clock, or clears on START or STOP
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sda_oe_q <= 1'b0;
    end else if (start_det || stop_det) begin
      sda_oe_q <= 1'b0;
    end else if (dec) begin
      // pull low through the ninth pulse
      sda_oe_q <= (state_q == S_ADDR) ? addr_ack : rx_fire;
    end else if (scl_fall) begin
      unique case (state_q)
        S_ACK, S_TX_ACK: begin
          // Zero bits pull, one bits release
          sda_oe_q <= tx_take & ~tx_data[7];
        end
        S_TX: begin
          sda_oe_q <= (cnt_q == 3'd7) ? 1'b0 : ~tx_sh_q[6];
        end
        default: begin
          sda_oe_q <= 1'b0;
        end
      endcase
    end
  end

  // open-drain data only, no clock drive
  assign sda_out = 1'b0;
  assign sda_oe = sda_oe_q;
  assign link_active = (state_q != S_IDLE);

  // ----------------------------------------
  // Store command
  // ----------------------------------------
  // first data byte may be the store command
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      commit_q <= 1'b0;
    end else begin
      commit_q <= rx_fire & first_q & deferred_store_select & (sh_q == `TWS_STORE_CMD);
    end
  end
  assign commit_to_nonvolatile_command = commit_q;

  // ----------------------------------------
  // Received-byte buffer
  // ----------------------------------------
  tws_skid_buf #(.DW(9), .DEPTH(`TWS_BUF_DEPTH)) u_buf (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .in_if(rx_if),
    .out_valid(rx_valid),
    .out_ready(rx_ready),
    .out_data({rx_first, rx_data})
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_drive_clock_low;
    @(posedge ref_clk) disable iff (!rst_b)
      $changed(sda_oe_q) |-> (!scl_s || $past(start_det) || $past(stop_det));
  endproperty
  a_drive_clock_low: assert property (p_drive_clock_low) else $error("data drive changed with clock high");

  property p_start_addr;
    @(posedge ref_clk) disable iff (!rst_b)
      start_det |=> (state_q == S_ADDR) && (cnt_q == 3'h0) && !sda_oe_q;
  endproperty
  a_start_addr: assert property (p_start_addr) else $error("start not taken");

  property p_stop_idle;
    @(posedge ref_clk) disable iff (!rst_b)
      (stop_det && !start_det) |=> (state_q == S_IDLE) && !sda_oe_q;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("stop not taken");

  property p_busy_nack;
    @(posedge ref_clk) disable iff (!rst_b)
      (dec && nv_busy) |=> !sda_oe_q && (state_q == S_IGNORE);
  endproperty
  a_busy_nack: assert property (p_busy_nack) else $error("busy request acknowledged");

  property p_ack_held;
    @(posedge ref_clk) disable iff (!rst_b)
      (state_q == S_ACK) |-> sda_oe_q;
  endproperty
  a_ack_held: assert property (p_ack_held) else $error("ack not driven");

  property p_release_mack;
    @(posedge ref_clk) disable iff (!rst_b)
      (state_q == S_TX_ACK) |-> !sda_oe_q;
  endproperty
  a_release_mack: assert property (p_release_mack) else $error("line held in master ack");

  property p_wrong_addr;
    @(posedge ref_clk) disable iff (!rst_b)
      (dec && state_q == S_ADDR && !addr_match) |=> (state_q == S_IGNORE) ##1 !sda_oe_q;
  endproperty
  a_wrong_addr: assert property (p_wrong_addr) else $error("foreign address acknowledged");

  property p_tx_bit;
    @(posedge ref_clk) disable iff (!rst_b)
      (state_q == S_TX && $stable(state_q) && !scl_fall) |-> (sda_oe_q == ~tx_sh_q[7]);
  endproperty
  a_tx_bit: assert property (p_tx_bit) else $error("transmit bit wrong");

  property p_commit_pulse;
    @(posedge ref_clk) disable iff (!rst_b)
      commit_q |-> $past(deferred_store_select) ##1 !commit_q;
  endproperty
  a_commit_pulse: assert property (p_commit_pulse) else $error("store pulse wrong");
endmodule // tws_slave_port

// file: tws_stream_if.sv
// Valid/ready stream carrier between the port modules
`timescale 1ns/10ps
interface tws_stream_if #(parameter int DW = 9);
  logic valid; // Word offered
  logic ready; // Word accepted
  logic [DW-1:0] data; // Word
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface // tws_stream_if

// file: tws_sync.sv
// Two-stage synchroniser for pin levels
`timescale 1ns/10ps
module tws_sync #(
  parameter int W = 2
) (
  input wire logic ref_clk, // System clock
  input wire logic rst_b, // Async reset, active low
  input wire logic [W-1:0] async_in, // Pin levels
  output logic [W-1:0] sync_out // Synchronised levels
);
  logic [W-1:0] meta_q; // First stage, read only by second
  // ----------------------------------------
  // Two flops
  // ----------------------------------------
  // Released bus idles high, so reset to ones
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= '1;
      sync_out <= '1;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule // tws_sync
